/* File: inc/sbc_regs.vh */
`ifndef SBC_REGS_VH
`define SBC_REGS_VH
// register offsets
`define SBC_A_CTRL 4'h0
`define SBC_A_WAKE_EN 4'h1
`define SBC_A_WAKE_POL 4'h2
`define SBC_A_PULL_UP 4'h3
`define SBC_A_PULL_DN 4'h4
`define SBC_A_FLAGS 4'h5
`define SBC_A_STATUS 4'h6
`define SBC_A_CMD 4'h7
// ctrl fields
`define SBC_CTRL_RETAIN 0
`define SBC_CTRL_TMR_SD 1
// cmd values
`define SBC_CMD_STANDBY 8'hA5
`define SBC_CMD_SHUTDOWN 8'h5A
// wake flag bit positions
`define SBC_F_RST 5
`define SBC_F_WDG 6
`define SBC_F_TMR 7
`define SBC_F_CRY 8
`define SBC_F_SD 9
// widths and resets
`define SBC_NPIN 5
`define SBC_CTRL_RST 2'h0
`define SBC_CLK_MSI_SB 2'h1
`define SBC_CLK_MSI_SD 2'h2
`define SBC_CLK_RUN 2'h0
`endif

/* File: core/sbc_sync.v */
`timescale 1ns/10ps
module sbc_sync
(
   input wire i_clk,
   input wire i_rstn,
   input wire [7:0] i_d,
   output wire [7:0] o_q
);
   reg [7:0] s1_q;
   reg [7:0] s2_q;
   always @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         s1_q <= 8'h00;
         s2_q <= 8'h00;
      end
      else
      begin
         s1_q <= i_d;
         s2_q <= s1_q;
      end
   end
   assign o_q = s2_q;
endmodule // sbc_sync

/* File: core/sbc_power_ctrl.v */
// Function
// - standby exits: reset, watchdog, pin, timer, crystal
// - standby variant retains second sram
// - standby powers off cpu, flash, first sram
// - pins hold chosen pull state while asleep
// - shutdown kills regulator, pll, all oscillators except the crystal when the timer runs
// - shutdown timer optionally runs on crystal
// - shutdown: no brownout, no backup switchover
// - shutdown exit loses all non-backup state
// - shutdown exits: reset, pin, timer only
// - shutdown wake uses multispeed rc at 4MHz
// - pull settings discarded on shutdown exit
// - exactly five wake pins
`timescale 1ns/10ps
`include "sbc_regs.vh"
module sbc_power_ctrl
(
   input wire i_clk,
   input wire i_rstn,
   input wire [3:0] i_addr,
   input wire [15:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output reg [15:0] o_rdata,
   input wire i_ext_reset_pin_n,
   input wire [4:0] i_wake_pin,
   input wire i_independent_watchdog_rst,
   input wire i_timer_event,
   input wire i_clock_failure_detector,
   output reg o_core_supply_domain_on,
   output reg o_low_power_regulator_on,
   output reg o_cpu_pwr_on,
   output reg o_flash_pwr_on,
   output reg o_first_sram_pwr_on,
   output reg o_second_sram_pwr_on,
   output reg o_periph_pwr_on,
   output reg o_pll_on,
   output reg o_fast_internal_rc_on,
   output reg o_fast_external_crystal_on,
   output reg o_multispeed_rc_on,
   output reg o_low_speed_rc_on,
   output reg o_low_speed_crystal_on,
   output reg o_brownout_monitor_on,
   output reg o_backup_switch_en,
   output reg o_timer_on,
   output reg o_watchdog_on,
   output reg o_state_reset,
   output reg [1:0] o_sysclk_sel,
   output reg [15:0] o_pin_pull_up,
   output reg [15:0] o_pin_pull_dn
);
   localparam ST_RUN = 3'b001;
   localparam ST_SB = 3'b010;
   localparam ST_SD = 3'b100;
   reg [2:0] st_q;
   reg [1:0] ctrl_q;
   reg [4:0] wen_q;
   reg [4:0] wpol_q;
   reg [15:0] pu_q;
   reg [15:0] pd_q;
   reg [9:0] flags_q;
   reg [4:0] wprev_q;
   wire [7:0] sy;
   wire [4:0] wp;
   wire rst_in;
   wire wdg_in;
   wire tmr_in;
   wire cry_in;
   wire [4:0] wedge;
   wire pin_wake;
   wire sb_exit;
   wire sd_exit;
   wire [9:0] ev;
   // pins and async sources pass two flops first
   sbc_sync u_sync
   (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_d({~i_ext_reset_pin_n, i_independent_watchdog_rst,
            i_timer_event, i_wake_pin}),
      .o_q(sy)
   );
   assign wp = sy[4:0];
   assign tmr_in = sy[5];
   assign wdg_in = sy[6];
   assign rst_in = sy[7];
   reg cry_s1_q;
   reg cry_s2_q;
   assign cry_in = cry_s2_q;
   // edge of selected polarity on enabled pins only
   genvar g;
   generate
      for (g = 0; g < `SBC_NPIN; g = g + 1)
      begin : g_wake
         assign wedge[g] = wen_q[g] & (wpol_q[g] ?
            (wprev_q[g] & ~wp[g]) : (~wprev_q[g] & wp[g]));
      end
   endgenerate
   assign pin_wake = |wedge;
   // watchdog and crystal fault do not end shutdown
   assign sb_exit = rst_in | wdg_in | pin_wake | tmr_in | cry_in;
   assign sd_exit = rst_in | pin_wake | (tmr_in & ctrl_q[`SBC_CTRL_TMR_SD]);
   assign ev = {(st_q == ST_SD), cry_in & (st_q == ST_SB),
      tmr_in, wdg_in & (st_q == ST_SB), rst_in, wedge};
   always @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         cry_s1_q <= 1'b0;
         cry_s2_q <= 1'b0;
      end
      else
      begin
         cry_s1_q <= i_clock_failure_detector;
         cry_s2_q <= cry_s1_q;
      end
   end
   always @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         st_q <= ST_RUN;
         ctrl_q <= `SBC_CTRL_RST;
         wen_q <= 5'h00;
         wpol_q <= 5'h00;
         pu_q <= 16'h0000;
         pd_q <= 16'h0000;
         flags_q <= 10'h000;
         wprev_q <= 5'h00;
         o_state_reset <= 1'b0;
         o_sysclk_sel <= `SBC_CLK_RUN;
      end
      else
      begin
         wprev_q <= wp;
         o_state_reset <= 1'b0;
         case (st_q)
            ST_RUN:
            begin
               if (i_wr && i_addr == `SBC_A_CMD &&
                   i_wdata[7:0] == `SBC_CMD_STANDBY)
                  st_q <= ST_SB;
               else if (i_wr && i_addr == `SBC_A_CMD &&
                   i_wdata[7:0] == `SBC_CMD_SHUTDOWN)
                  st_q <= ST_SD;
               if (i_wr && i_addr == `SBC_A_CTRL)
                  ctrl_q <= i_wdata[1:0];
               if (i_wr && i_addr == `SBC_A_WAKE_EN)
                  wen_q <= i_wdata[4:0];
               if (i_wr && i_addr == `SBC_A_WAKE_POL)
                  wpol_q <= i_wdata[4:0];
               if (i_wr && i_addr == `SBC_A_PULL_UP)
                  pu_q <= i_wdata;
               if (i_wr && i_addr == `SBC_A_PULL_DN)
                  pd_q <= i_wdata;
               // write one clears; no events arrive while running
               if (i_wr && i_addr == `SBC_A_FLAGS)
                  flags_q <= flags_q & ~i_wdata[9:0];
            end
            ST_SB:
            begin
               if (sb_exit)
               begin
                  st_q <= ST_RUN;
                  flags_q <= ev;
                  o_sysclk_sel <= `SBC_CLK_MSI_SB;
               end
            end
            ST_SD:
            begin
               if (sd_exit)
               begin
                  st_q <= ST_RUN;
                  flags_q <= ev;
                  // config lost; only flags (backup domain) kept
                  ctrl_q <= `SBC_CTRL_RST;
                  wen_q <= 5'h00;
                  wpol_q <= 5'h00;
                  pu_q <= 16'h0000;
                  pd_q <= 16'h0000;
                  o_state_reset <= 1'b1;
                  o_sysclk_sel <= `SBC_CLK_MSI_SD;
               end
            end
            default:
               st_q <= ST_RUN;
         endcase
      end
   end
   // power and clock enables decoded from state, registered
   always @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         o_core_supply_domain_on <= 1'b1;
         o_low_power_regulator_on <= 1'b0;
         o_cpu_pwr_on <= 1'b1;
         o_flash_pwr_on <= 1'b1;
         o_first_sram_pwr_on <= 1'b1;
         o_second_sram_pwr_on <= 1'b1;
         o_periph_pwr_on <= 1'b1;
         o_pll_on <= 1'b1;
         o_fast_internal_rc_on <= 1'b1;
         o_fast_external_crystal_on <= 1'b1;
         o_multispeed_rc_on <= 1'b1;
         o_low_speed_rc_on <= 1'b1;
         o_low_speed_crystal_on <= 1'b1;
         o_brownout_monitor_on <= 1'b1;
         o_backup_switch_en <= 1'b1;
         o_timer_on <= 1'b1;
         o_watchdog_on <= 1'b1;
         o_pin_pull_up <= 16'h0000;
         o_pin_pull_dn <= 16'h0000;
      end
      else
      begin
         o_core_supply_domain_on <= (st_q == ST_RUN);
         o_low_power_regulator_on <= (st_q == ST_SB) &
            ctrl_q[`SBC_CTRL_RETAIN];
         o_cpu_pwr_on <= (st_q == ST_RUN);
         o_flash_pwr_on <= (st_q == ST_RUN);
         o_first_sram_pwr_on <= (st_q == ST_RUN);
         o_second_sram_pwr_on <= (st_q == ST_RUN) |
            ((st_q == ST_SB) & ctrl_q[`SBC_CTRL_RETAIN]);
         o_periph_pwr_on <= (st_q == ST_RUN);
         o_pll_on <= (st_q == ST_RUN);
         o_fast_internal_rc_on <= (st_q == ST_RUN);
         o_fast_external_crystal_on <= (st_q == ST_RUN);
         o_multispeed_rc_on <= (st_q == ST_RUN);
         o_low_speed_rc_on <= (st_q != ST_SD);
         // crystal kept in shutdown only to feed the timer
         o_low_speed_crystal_on <= (st_q != ST_SD) |
            ctrl_q[`SBC_CTRL_TMR_SD];
         o_timer_on <= (st_q != ST_SD) | ctrl_q[`SBC_CTRL_TMR_SD];
         o_brownout_monitor_on <= (st_q != ST_SD);
         o_backup_switch_en <= (st_q != ST_SD);
         o_watchdog_on <= (st_q != ST_SD);
         o_pin_pull_up <= pu_q;
         o_pin_pull_dn <= pd_q;
      end
   end
   // read port, data one cycle after strobe
   always @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         o_rdata <= 16'h0000;
      else if (i_rd)
      begin
         if (i_addr == `SBC_A_CTRL)
            o_rdata <= {14'h0000, ctrl_q};
         else if (i_addr == `SBC_A_WAKE_EN)
            o_rdata <= {11'h000, wen_q};
         else if (i_addr == `SBC_A_WAKE_POL)
            o_rdata <= {11'h000, wpol_q};
         else if (i_addr == `SBC_A_PULL_UP)
            o_rdata <= pu_q;
         else if (i_addr == `SBC_A_PULL_DN)
            o_rdata <= pd_q;
         else if (i_addr == `SBC_A_FLAGS)
            o_rdata <= {6'h00, flags_q};
         else if (i_addr == `SBC_A_STATUS)
            o_rdata <= {11'h000, o_sysclk_sel, st_q};
         else
            o_rdata <= 16'h0000;
      end
      else
         o_rdata <= 16'h0000;
   end
endmodule // sbc_power_ctrl

/* File: verification/sbc_power_ctrl_sva.sv */
`timescale 1ns/10ps
module sbc_power_ctrl_sva
(
   input wire i_clk,
   input wire i_rstn,
   input wire [3:0] i_addr,
   input wire [15:0] i_wdata,
   input wire i_wr,
   input wire i_independent_watchdog_rst,
   input wire o_core_supply_domain_on,
   input wire o_low_power_regulator_on,
   input wire o_cpu_pwr_on,
   input wire o_first_sram_pwr_on,
   input wire o_second_sram_pwr_on,
   input wire o_pll_on,
   input wire o_low_speed_rc_on,
   input wire o_brownout_monitor_on,
   input wire o_backup_switch_en,
   input wire o_watchdog_on,
   input wire o_state_reset,
   input wire [1:0] o_sysclk_sel,
   input wire [15:0] o_pin_pull_up
);
default clocking @(posedge i_clk); endclocking
default disable iff (!i_rstn);
wire cmd = i_wr && i_addr == 4'h7 && o_cpu_pwr_on;
wire sb = cmd && i_wdata[7:0] == 8'hA5;
wire sd = cmd && i_wdata[7:0] == 8'h5A;
a_standby_power: assert property (sb |-> ##2 !o_cpu_pwr_on && !o_pll_on &&
   !o_first_sram_pwr_on && o_low_speed_rc_on && o_watchdog_on &&
   o_brownout_monitor_on) else $error("standby power wrong");
a_retain_sram: assert property (sb |-> ##2 o_second_sram_pwr_on ==
   o_low_power_regulator_on) else $error("retention wrong");
a_shutdown_off: assert property (sd |-> ##2 !o_core_supply_domain_on &&
   !o_pll_on && !o_low_speed_rc_on) else $error("shutdown on");
a_no_brownout: assert property (!o_low_speed_rc_on |-> !o_pll_on &&
   !o_brownout_monitor_on && !o_backup_switch_en)
   else $error("monitor on");
a_wake_clock: assert property ($rose(o_cpu_pwr_on) |-> o_sysclk_sel != 2'h0)
   else $error("wake clock");
a_sd_clock: assert property (o_state_reset |-> ##[0:1] o_sysclk_sel == 2'h2)
   else $error("shutdown clock");
a_loss_pulse: assert property (o_state_reset |=> !o_state_reset)
   else $error("loss pulse");
a_pull_clear: assert property (o_state_reset |-> ##[0:2]
   o_pin_pull_up == 16'h0000) else $error("pulls kept");
a_pull_hold: assert property (!o_cpu_pwr_on &&
   !o_state_reset |=> $stable(o_pin_pull_up)) else $error("pulls");
a_wdg_wake: assert property (!o_cpu_pwr_on && o_low_speed_rc_on &&
   i_independent_watchdog_rst |-> ##[1:8] o_cpu_pwr_on)
   else $error("no wake");
endmodule // sbc_power_ctrl_sva
bind sbc_power_ctrl sbc_power_ctrl_sva i_sva (.*);

/* File: verification/sbc_wake_src.sv */
`timescale 1ns/10ps
module sbc_wake_src
(
   input wire i_clk,
   input wire i_fire,
   input wire [3:0] i_src,
   output wire o_rstn,
   output wire [4:0] o_pin,
   output wire o_wdg,
   output wire o_tmr,
   output wire o_cry
);
reg [3:0] s = 4'h0;
reg [2:0] n = 3'h0;
wire a = n != 3'h0;
// held 4 cycles so the two-flop sync sees it
always @(posedge i_clk)
begin
   n <= i_fire ? 3'h4 : n - {2'h0, a};
   if (i_fire)
      s <= i_src;
end
assign o_pin = a && s < 4'h5 ? 5'h01 << s : 5'h00;
assign o_rstn = !(a && s == 4'h5);
assign o_wdg = a && s == 4'h6;
assign o_tmr = a && s == 4'h7;
assign o_cry = a && s == 4'h8;
endmodule // sbc_wake_src

/* File: verification/tb_sbc_power_ctrl.sv */
`timescale 1ns/10ps
`define CHK(n, e, v) begin num_checks++; if ((v) !== (e)) begin \
   mismatches++; $display("mismatch %s exp %h got %h", n, e, v); end end
module tb_sbc_power_ctrl;
reg i_clk = 1'b0;
reg i_rstn = 1'b0;
reg [3:0] i_addr = 4'h0;
reg [15:0] i_wdata = 16'h0000;
reg i_wr = 1'b0;
reg i_rd = 1'b0;
reg fire = 1'b0;
reg [3:0] src = 4'h0;
wire [15:0] o_rdata, o_pin_pull_up, o_pin_pull_dn;
wire [4:0] i_wake_pin;
wire [1:0] o_sysclk_sel;
wire i_ext_reset_pin_n, i_independent_watchdog_rst, i_timer_event,
   i_clock_failure_detector, o_core_supply_domain_on,
   o_low_power_regulator_on, o_cpu_pwr_on, o_flash_pwr_on,
   o_first_sram_pwr_on, o_second_sram_pwr_on, o_periph_pwr_on, o_pll_on,
   o_fast_internal_rc_on, o_fast_external_crystal_on, o_multispeed_rc_on,
   o_low_speed_rc_on, o_low_speed_crystal_on, o_brownout_monitor_on,
   o_backup_switch_en, o_timer_on, o_watchdog_on, o_state_reset;
int mismatches = 0;
int num_checks = 0;
logic [15:0] d;
logic [7:0] c;
logic [3:0] s;
logic [4:0] e;
logic w;
logic [17:0] rows [0:14] = '{{8'hA5,4'h0,5'h1F,1'b1},
   {8'hA5,4'h1,5'h1F,1'b1}, {8'hA5,4'h2,5'h1F,1'b1},
   {8'hA5,4'h3,5'h1F,1'b1}, {8'hA5,4'h4,5'h1F,1'b1},
   {8'hA5,4'h5,5'h1F,1'b1}, {8'hA5,4'h6,5'h1F,1'b1},
   {8'hA5,4'h7,5'h1F,1'b1}, {8'hA5,4'h8,5'h1F,1'b1},
   {8'hA5,4'h2,5'h1B,1'b0}, {8'h5A,4'h4,5'h1F,1'b1},
   {8'h5A,4'h5,5'h1F,1'b1}, {8'h5A,4'h7,5'h1F,1'b1},
   {8'h5A,4'h6,5'h1F,1'b0}, {8'h5A,4'h8,5'h1F,1'b0}};
always #12.5 i_clk = ~i_clk;
sbc_power_ctrl i_dut (.*);
sbc_wake_src u_src (.i_clk(i_clk), .i_fire(fire), .i_src(src),
   .o_rstn(i_ext_reset_pin_n), .o_pin(i_wake_pin),
   .o_wdg(i_independent_watchdog_rst), .o_tmr(i_timer_event),
   .o_cry(i_clock_failure_detector));
task wr(input [3:0] a, input [15:0] v);
begin
   @(posedge i_clk);
   i_addr <= a;
   i_wdata <= v;
   i_wr <= 1'b1;
   @(posedge i_clk);
   i_wr <= 1'b0;
end
endtask
task rd(input [3:0] a);
begin
   @(posedge i_clk);
   i_addr <= a;
   i_rd <= 1'b1;
   @(posedge i_clk);
   i_rd <= 1'b0;
   #1 d = o_rdata;
end
endtask
task kick(input [3:0] k);
begin
   @(posedge i_clk);
   src <= k;
   fire <= 1'b1;
   @(posedge i_clk);
   fire <= 1'b0;
end
endtask
task complete_run;
begin
   if (mismatches == 0 && num_checks > 0)
      $display("[ PASS ]");
   else
      $display("[ FAIL ]");
   $finish;
end
endtask
initial
begin
   repeat (12) @(posedge i_clk);
   i_rstn <= 1'b1;
   #1 `CHK("rst", 4'h8, {o_cpu_pwr_on, o_low_power_regulator_on, o_sysclk_sel})
   rd(4'h6);
   `CHK("status", 16'h0001, d)
   rd(4'h8);
   `CHK("unmapped", 16'h0000, d)
   for (int r = 0; r < 15; r++)
   begin
      {c, s, e, w} = rows[r];
      wr(4'h0, 16'h0003);
      wr(4'h1, {11'h000, e});
      wr(4'h2, 16'h0000);
      wr(4'h3, 16'h00F0);
      wr(4'h4, 16'h000F);
      wr(4'h5, 16'h03FF);
      wr(4'h7, {8'h00, c});
      repeat (4) @(posedge i_clk);
      `CHK("pull", 16'h00F0, o_pin_pull_up)
      `CHK("pulldn", 16'h000F, o_pin_pull_dn)
      `CHK("pwr", {1'b0, c == 8'hA5, 2'b00}, {o_cpu_pwr_on,
         o_second_sram_pwr_on, o_first_sram_pwr_on, o_pll_on})
      `CHK("osc", 7'h03, {o_flash_pwr_on, o_periph_pwr_on,
         o_fast_internal_rc_on, o_fast_external_crystal_on,
         o_multispeed_rc_on, o_low_speed_crystal_on, o_timer_on})
      kick(s);
      if (!w)
      begin
         // no wake expected; reset pin brings it back
         repeat (20) @(posedge i_clk);
         `CHK("asleep", 1'b0, o_cpu_pwr_on)
         kick(4'h5);
      end
      for (int k = 0; k < 40 && o_cpu_pwr_on !== 1'b1; k++)
         @(posedge i_clk);
      `CHK("awake", 1'b1, o_cpu_pwr_on)
      if (w)
      begin
         rd(4'h5);
         `CHK("flags", (16'h0001 << s) | {6'h00, c == 8'h5A, 9'h000}, d)
      end
      rd(4'h6);
      `CHK("status", {11'h000, c == 8'hA5 ? 2'h1 : 2'h2, 3'h1}, d)
      `CHK("pullx", c == 8'hA5 ? 16'h00F0 : 16'h0000, o_pin_pull_up)
   end
   // shutdown without timer: crystal off, timer must not wake
   wr(4'h0, 16'h0000);
   wr(4'h7, 16'h005A);
   repeat (4) @(posedge i_clk);
   `CHK("sd_lse", 2'b00, {o_low_speed_crystal_on, o_timer_on})
   kick(4'h7);
   repeat (20) @(posedge i_clk);
   `CHK("sd_tmr", 1'b0, o_cpu_pwr_on)
   // second reset while asleep
   i_rstn <= 1'b0;
   repeat (2) @(posedge i_clk);
   i_rstn <= 1'b1;
   #1 `CHK("rst2", 4'h8, {o_cpu_pwr_on, o_low_power_regulator_on, o_sysclk_sel})
   rd(4'h6);
   `CHK("status2", 16'h0001, d)
   rd(4'h5);
   `CHK("flags2", 16'h0000, d)
   complete_run;
end
initial
begin
   #100000;
   mismatches++;
   complete_run;
end
endmodule // tb_sbc_power_ctrl
